// ### rtl/dac_update_sequencer.sv
// control core: command decode, queue, busy timing, load and monitor select
// assumes host pins are asynchronous; analog and serial framing live elsewhere
`timescale 1ns/1ps
`default_nettype none
module dac_update_sequencer
  import dac_seq_pkg::*;
#(
  parameter int RESET_CNT = RESET_CYCLES,
  parameter int POR_CNT   = POR_CYCLES,
  parameter int CLEAR_CNT = CLEAR_CYCLES,
  parameter int CALC_CNT  = CALC_CYCLES,
  parameter int QDEPTH    = QUEUE_DEPTH
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_b_i,
  input  wire logic              reset_pin_b_i,
  input  wire logic              async_clear_input_b_i,
  input  wire logic              load_output_strobe_b_i,
  input  wire logic              queue_enable_pin_i,
  input  wire logic              interface_select_pin_i,
  input  wire logic              two_wire_select_i,
  input  wire logic              power_down_i,
  input  wire logic              write_strobe_b_i,
  input  wire logic              frame_sync_b_i,
  input  wire logic              cmd_valid_i,
  input  wire cmd_s              cmd_i,
  output logic                   cmd_ready_o,
  output logic                   busy_b_o,
  output logic [NUM_CH*DATA_W-1:0] dac_regs_o,
  output logic [NUM_CH-1:0]      chan_out_en_o,
  output logic [NUM_CH-1:0]      chan_pd_load_o,
  output logic [5:0]             monitor_sel_o,
  output logic                   monitor_output_oe_o,
  output logic                   monitor_enable_bit_o,
  output logic                   queue_active_o,
  output if_mode_s               if_mode_o,
  output logic                   if_awake_o
);
  localparam int AW = $clog2(QDEPTH);
  localparam int CW = 24;

  typedef enum { ST_POR, ST_RESET, ST_CLEAR, ST_IDLE, ST_CALC } state_e;

  // reset release and pin synchronisers
  logic rst_s1, rst_n;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  logic reset_lvl, reset_fall, clr_lvl, load_lvl, load_fall, wr_lvl, wr_fall, fs_lvl, fs_fall;
  fall_sync u_reset (.mclk_i(mclk_i), .rst_n_i(rst_n), .pin_i(reset_pin_b_i),
                     .level_o(reset_lvl), .fall_o(reset_fall));
  fall_sync u_clr   (.mclk_i(mclk_i), .rst_n_i(rst_n), .pin_i(async_clear_input_b_i),
                     .level_o(clr_lvl), .fall_o());
  fall_sync u_load  (.mclk_i(mclk_i), .rst_n_i(rst_n), .pin_i(load_output_strobe_b_i),
                     .level_o(load_lvl), .fall_o(load_fall));
  fall_sync u_wr    (.mclk_i(mclk_i), .rst_n_i(rst_n), .pin_i(write_strobe_b_i),
                     .level_o(wr_lvl), .fall_o(wr_fall));
  fall_sync u_fs    (.mclk_i(mclk_i), .rst_n_i(rst_n), .pin_i(frame_sync_b_i),
                     .level_o(fs_lvl), .fall_o(fs_fall));

  logic q_pin_s1, q_pin, sel_s1, sel, tw_s1, tw, pd_s1, pd;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      {q_pin_s1, q_pin, sel_s1, sel, tw_s1, tw, pd_s1, pd} <= 8'h00;
    end else begin
      {q_pin_s1, sel_s1, tw_s1, pd_s1} <= {queue_enable_pin_i, interface_select_pin_i,
                                           two_wire_select_i, power_down_i};
      {q_pin, sel, tw, pd} <= {q_pin_s1, sel_s1, tw_s1, pd_s1};
    end
  end

  // control state
  state_e                  state, next_state;
  logic [CW-1:0]           cnt, next_cnt;
  logic [13:0]             ctrl, next_ctrl;
  logic [13:0]             clr_code, next_clr_code;
  logic [5:0]              mon_sel, next_mon_sel;
  logic [DATA_W-1:0]       computed_data_register [NUM_CH];
  logic [DATA_W-1:0]       next_computed_data_register [NUM_CH];
  logic [DATA_W-1:0]       dac [NUM_CH];
  logic [DATA_W-1:0]       next_dac [NUM_CH];
  logic [NUM_CH-1:0]       dirty, next_dirty;
  logic                    load_pend, next_load_pend;
  logic                    q_act, next_q_act;
  logic                    awake, next_awake;
  logic [AW:0]             wptr, next_wptr, rptr, next_rptr;
  logic                    rd_pend, next_rd_pend;
  cmd_s                    q_rdata;
  cmd_s                    cur, next_cur;
  logic                    cur_valid, next_cur_valid;

  logic q_full, q_empty, if_on, accept, q_we, pop;
  if_sel_e if_sel;

  always_comb begin
    if (!sel) if_sel = MODE_PAR;                                                // RQ21
    else if (tw) if_sel = MODE_TWI;
    else if_sel = MODE_SPI;
  end

  assign q_full  = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign q_empty = (wptr == rptr);
  // interfaces shut during por, reset and power-down
  assign if_on   = (state != ST_POR) && (state != ST_RESET) && !pd;                // RQ7
  assign accept  = if_on && cmd_valid_i && (q_act ? !q_full : !cur_valid);        // RQ17
  assign q_we    = accept && q_act;
  assign pop     = q_act && !q_empty && !rd_pend && !cur_valid && (state == ST_IDLE);
  assign cmd_ready_o = if_on && (q_act ? !q_full : !cur_valid);

  cmd_queue_mem #(.DEPTH(QDEPTH), .AW(AW)) u_mem (
    .mclk_i (mclk_i),
    .we_i   (q_we),
    .waddr_i(wptr[AW-1:0]),
    .wdata_i(cmd_i),
    .raddr_i(rptr[AW-1:0]),
    .rdata_o(q_rdata)
  );

  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_ctrl      = ctrl;
    next_clr_code  = clr_code;
    next_mon_sel   = mon_sel;
    next_computed_data_register = computed_data_register;
    next_dac       = dac;
    next_dirty     = dirty;
    next_load_pend = load_pend;
    next_q_act     = q_act;
    next_awake     = awake;
    next_wptr      = wptr + (AW+1)'(q_we);
    next_rptr      = rptr + (AW+1)'(pop);
    next_rd_pend   = pop;
    next_cur       = cur;
    next_cur_valid = cur_valid;
    if (wr_fall && !sel) next_awake = 1'b1;                                     // RQ22
    else if (fs_fall && sel) next_awake = 1'b1;                                 // RQ22
    else if (wr_lvl && fs_lvl && !cur_valid && q_empty) next_awake = 1'b0;
    if (accept && !q_act) begin
      next_cur       = cmd_i;
      next_cur_valid = 1'b1;
    end
    if (rd_pend) begin
      next_cur       = q_rdata;
      next_cur_valid = 1'b1;
    end
    // strobes during calculation are remembered
    if ((load_fall || !load_lvl) && state != ST_POR && state != ST_RESET)
      next_load_pend = 1'b1;                                                   // RQ13
    case (state)
      ST_POR, ST_RESET: begin
        next_load_pend = 1'b0;                                                  // RQ7
        next_cur_valid = 1'b0;
        if (cnt == '0) begin
          next_state = ST_IDLE;
          next_q_act = q_pin && !sel;                                           // RQ15 RQ16
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_CLEAR: begin
        if (cnt == '0) begin
          next_state = ST_IDLE;
          next_q_act = q_pin && !sel;                                           // RQ15
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_CALC: begin
        // writes still land while busy, outputs frozen
        if (cnt == '0) next_state = ST_IDLE;                                    // RQ12
        else next_cnt = cnt - 1'b1;
      end
      ST_IDLE: begin
        if (cur_valid) begin
          next_cur_valid = 1'b0;
          if (cur.regsel == REGSEL_SPECIAL) begin
            if (cur.chan == ADDR_MONITOR)
              next_mon_sel = cur.data[MON_FIELD_LSB +: 6];                       // RQ1
            else if (cur.chan == 6'h0c) next_ctrl = cur.data;
            else if (cur.chan == 6'h01) next_clr_code = cur.data;
          end else if (cur.chan < 6'(NUM_CH)) begin
            // gain and offset arithmetic lives outside; input value stands in
            next_computed_data_register[cur.chan[5:0]] = cur.data;              // RQ11
            next_dirty[cur.chan[5:0]] = 1'b1;                                   // RQ14
            next_state = ST_CALC;                                               // RQ11
            next_cnt   = CW'(CALC_CNT - 1);
          end
        end else if (load_pend && (!q_act || q_empty) && !rd_pend) begin
          for (int i = 0; i < NUM_CH; i++) begin
            if (dirty[i]) next_dac[i] = computed_data_register[i];              // RQ14
          end
          next_dirty     = '0;
          next_load_pend = load_fall || !load_lvl;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (!clr_lvl && state != ST_POR && state != ST_RESET) begin
      for (int i = 0; i < NUM_CH; i++) next_dac[i] = clr_code;                  // RQ10
      next_state = ST_CLEAR;
      next_cnt   = CW'(CLEAR_CNT - 1);
    end
    // level of the reset pin ignored, only its fall restarts
    if (reset_fall && !pd) begin                                                // RQ8
      next_state    = ST_RESET;                                                 // RQ5
      next_cnt      = CW'(RESET_CNT - 1);                                       // RQ6 RQ24
      next_ctrl     = CR_RESET;
      next_clr_code = CLEAR_CODE_RESET;
      next_mon_sel  = MON_FLOAT_CODE;
      next_dirty    = '0;
      next_wptr     = '0;
      next_rptr     = '0;
      next_rd_pend  = 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        next_computed_data_register[i] = '0;
        next_dac[i] = '0;                                                       // RQ5
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_POR;                                                      // RQ19
      cnt       <= CW'(POR_CNT - 1);
      ctrl      <= CR_RESET;
      clr_code  <= CLEAR_CODE_RESET;
      mon_sel   <= MON_FLOAT_CODE;
      computed_data_register <= '{default: '0};
      dac       <= '{default: '0};
      dirty     <= '0;
      load_pend <= 1'b0;
      q_act     <= 1'b0;
      awake     <= 1'b0;
      wptr      <= '0;
      rptr      <= '0;
      rd_pend   <= 1'b0;
      cur       <= '0;
      cur_valid <= 1'b0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      ctrl      <= next_ctrl;
      clr_code  <= next_clr_code;
      mon_sel   <= next_mon_sel;
      computed_data_register <= next_computed_data_register;
      dac       <= next_dac;
      dirty     <= next_dirty;
      load_pend <= next_load_pend;
      q_act     <= next_q_act;
      awake     <= next_awake;
      wptr      <= next_wptr;
      rptr      <= next_rptr;
      rd_pend   <= next_rd_pend;
      cur       <= next_cur;
      cur_valid <= next_cur_valid;
    end
  end

  logic mon_on;
  assign mon_on   = ctrl[CR_MON_EN_BIT];                                         // RQ23

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) dac_regs_o[i*DATA_W +: DATA_W] = dac[i];
    // power-down keeps every register; outputs change, interfaces shut and the reset pin is ignored
    for (int i = 0; i < NUM_CH; i++) begin
      chan_out_en_o[i]  = (state != ST_POR) && !pd;                              // RQ19 RQ20
      chan_pd_load_o[i] = pd && !ctrl[CR_PD_FLOAT_BIT];                          // RQ20
    end
    if (mon_on) chan_out_en_o[NUM_CH-1] = 1'b0;                                  // RQ2
  end

  // busy low across por, reset, clear, calc and queue drain
  assign busy_b_o = (state == ST_IDLE) && !cur_valid && !rd_pend &&
                    !(q_act && !q_empty);                                        // RQ6 RQ18
  assign monitor_sel_o        = mon_sel;                                         // RQ2
  assign monitor_output_oe_o  = mon_on && (mon_sel != MON_FLOAT_CODE) &&
                                (mon_sel <= MON_LAST_VALID) && !pd;               // RQ3
  assign monitor_enable_bit_o = mon_on;
  assign queue_active_o       = q_act;
  assign if_mode_o            = '{parallel:  if_sel == MODE_PAR,
                                  two_wire:  if_sel == MODE_TWI,
                                  four_wire: if_sel == MODE_SPI};
  assign if_awake_o           = awake;

  a_reset_busy: assert property (@(posedge mclk_i) disable iff (!rst_n)
    reset_fall && !pd |=> !busy_b_o [*8]) else $error("busy not low after reset edge"); // RQ6
  a_reset_clears: assert property (@(posedge mclk_i) disable iff (!rst_n)
    reset_fall && !pd |=> dac_regs_o == '0) else $error("dac not cleared by reset"); // RQ5
  a_mon_float: assert property (@(posedge mclk_i) disable iff (!rst_n)
    mon_sel == MON_FLOAT_CODE |-> !monitor_output_oe_o) else $error("monitor driven"); // RQ3
  a_mon_decode: assert property (@(posedge mclk_i) disable iff (!rst_n)
    state == ST_IDLE && cur_valid && cur.regsel == REGSEL_SPECIAL && cur.chan == ADDR_MONITOR
    && !reset_fall |=> mon_sel == $past(cur.data[13:8])) else $error("monitor select lost"); // RQ1
  a_calc_busy: assert property (@(posedge mclk_i) disable iff (!rst_n)
    state == ST_CALC |-> !busy_b_o) else $error("busy high during calc"); // RQ11
  a_no_update_busy: assert property (@(posedge mclk_i) disable iff (!rst_n)
    state == ST_CALC && clr_lvl && !reset_fall |=> $stable(dac_regs_o))
    else $error("output changed while calculating"); // RQ12
  a_full_drop: assert property (@(posedge mclk_i) disable iff (!rst_n)
    q_act && q_full |-> !cmd_ready_o && !q_we) else $error("write taken while full"); // RQ17
  a_queue_busy: assert property (@(posedge mclk_i) disable iff (!rst_n)
    q_act && !q_empty |-> !busy_b_o) else $error("busy high with queue pending"); // RQ18
  a_strobe_held: assert property (@(posedge mclk_i) disable iff (!rst_n)
    load_fall && state == ST_CALC |=> load_pend) else $error("strobe lost while busy"); // RQ13
  a_pd_float: assert property (@(posedge mclk_i) disable iff (!rst_n)
    pd |-> chan_out_en_o == '0) else $error("output driven in power-down"); // RQ20
endmodule : dac_update_sequencer
`default_nettype wire

// ### common/dac_seq_pkg.sv
// package for the dac update sequencer: command codes, timing, carriers
// assumes a 40 MHz core clock; all timing counts derive from it
// What this block does
// RQ1 - decode special command 001010 as monitor select
// RQ2 - last channel output carries selected monitored channel
// RQ3 - monitor code 63 floats the monitor output
// RQ4 - host enables monitor before selecting a channel
// RQ5 - reset falling edge restores power-on register state
// RQ6 - reset lasts 270 us with busy low
// RQ7 - during reset busy ignore interfaces and load strobes
// RQ8 - after reset only next falling edge matters
// RQ9 - host resets only outside power-down
// RQ10 - clear low loads clear code within 35 us
// RQ11 - register writes trigger recalculation, busy low meanwhile
// RQ12 - writes accepted while calculating, no output update
// RQ13 - strobe during busy or held low remembered
// RQ14 - load only channels written since last strobe
// RQ15 - sample queue enable at power-up, clear, reset
// RQ16 - queue works only in parallel mode
// RQ17 - queue holds 128 writes, drops when full
// RQ18 - busy stays low while queue still draining
// RQ19 - power-on sequence: defaults, outputs floating, busy low
// RQ20 - power-down keeps registers, outputs float or load
// RQ21 - interface pins pick parallel, four-wire or two-wire
// RQ22 - interface wakes on write strobe or frame falling edge
// RQ23 - monitor enable bit switches last channel role
// RQ24 - durations are cycle counts from clock rate
package dac_seq_pkg;
  localparam int          CLK_KHZ        = 40000;
  localparam int          RESET_TIME_US  = 270;
  localparam int          CLEAR_TIME_US  = 35;
  localparam int          CALC_TIME_NS   = 500;
  localparam int          POR_TIME_US    = 270;
  localparam int          RESET_CYCLES   = RESET_TIME_US * CLK_KHZ / 1000;
  localparam int          CLEAR_CYCLES   = CLEAR_TIME_US * CLK_KHZ / 1000;
  localparam int          CALC_CYCLES    = (CALC_TIME_NS * CLK_KHZ + 999999) / 1000000;
  localparam int          POR_CYCLES     = POR_TIME_US * CLK_KHZ / 1000;
  localparam int          NUM_CH         = 40;
  localparam int          DATA_W         = 14;
  localparam int          QUEUE_DEPTH    = 128;
  localparam logic [5:0]  ADDR_MONITOR   = 6'h0a;
  localparam logic [1:0]  REGSEL_SPECIAL = 2'h0;
  localparam logic [1:0]  REGSEL_INPUT   = 2'h3;
  localparam logic [5:0]  MON_FLOAT_CODE = 6'h3f;
  localparam logic [5:0]  MON_LAST_VALID = 6'h26;
  localparam int          MON_FIELD_LSB  = 8;
  localparam int          CR_MON_EN_BIT  = 9;
  localparam int          CR_PD_FLOAT_BIT = 13;
  localparam logic [13:0] CR_RESET       = 14'h2000;
  localparam logic [13:0] GAIN_RESET     = 14'h3ffe;
  localparam logic [13:0] OFFSET_RESET   = 14'h2000;
  localparam logic [13:0] CLEAR_CODE_RESET = 14'h0000;

  typedef struct packed {
    logic [1:0]  regsel;
    logic [5:0]  chan;
    logic [13:0] data;
  } cmd_s;

  typedef struct packed {
    logic parallel;
    logic two_wire;
    logic four_wire;
  } if_mode_s;

  typedef enum logic [1:0] { MODE_NONE, MODE_PAR, MODE_SPI, MODE_TWI } if_sel_e;
endpackage : dac_seq_pkg

// ### rtl/cmd_queue_mem.sv
// instruction queue storage with registered read data
// assumes one writer and one reader on the same clock
`timescale 1ns/1ps
`default_nettype none
module cmd_queue_mem
  import dac_seq_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          mclk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire cmd_s          wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output var  cmd_s          rdata_o
);
  cmd_s mem [DEPTH];
  cmd_s next_rdata;

  always_comb begin
    next_rdata = mem[raddr_i];
  end

  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= next_rdata;
  end
endmodule : cmd_queue_mem
`default_nettype wire

// ### rtl/fall_sync.sv
// two-stage synchroniser with a falling-edge pulse
// assumes the input is asynchronous to mclk_i
`timescale 1ns/1ps
`default_nettype none
module fall_sync #(
  parameter logic INIT = 1'b1
) (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  output var  logic level_o,
  output var  logic fall_o
);
  logic stage1;
  logic stage2;
  logic stage3;
  logic next_stage3;

  always_comb begin
    next_stage3 = stage2;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
    end else begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= next_stage3;
    end
  end

  always_comb begin
    level_o = stage2;
    fall_o  = stage3 & ~stage2;
  end
endmodule : fall_sync
`default_nettype wire

// ### testbench/host_model.sv
// host controller model: command beats, strobes and mode pins for the sequencer
// assumes the bench calls its tasks; pins change only at falling mclk edges
`timescale 1ns/1ps
`default_nettype none
module host_model
  import dac_seq_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic cmd_ready_i,
  output var  logic reset_pin_b_o,
  output var  logic async_clear_input_b_o,
  output var  logic load_output_strobe_b_o,
  output var  logic queue_enable_pin_o,
  output var  logic interface_select_pin_o,
  output var  logic two_wire_select_o,
  output var  logic power_down_o,
  output var  logic write_strobe_b_o,
  output var  logic frame_sync_b_o,
  output var  logic cmd_valid_o,
  output var  cmd_s cmd_o
);
  logic qen = 1'b0;
  // queue pin forced low outside parallel mode
  assign queue_enable_pin_o = qen & ~interface_select_pin_o;
  initial begin
    {reset_pin_b_o, async_clear_input_b_o, load_output_strobe_b_o} = 3'h7;
    {write_strobe_b_o, frame_sync_b_o} = 2'h3;
    {interface_select_pin_o, two_wire_select_o, power_down_o, cmd_valid_o} = 4'h0;
    cmd_o = '0;
  end
  // request held until the edge that samples ready high; w = edges waited
  task automatic send(input cmd_s c, output int w);
    bit ok;
    @(negedge mclk_i);
    cmd_o = c;
    cmd_valid_o = 1'b1;
    if (interface_select_pin_o) frame_sync_b_o = 1'b0;
    else write_strobe_b_o = 1'b0;
    ok = 1'b0;
    for (w = 0; w < 2000 && !ok; w++) begin
      @(posedge mclk_i);
      ok = (cmd_ready_i === 1'b1);
    end
    @(negedge mclk_i);
    cmd_valid_o = 1'b0;
    {write_strobe_b_o, frame_sync_b_o} = 2'h3;
    // released bus must not keep the old value
    cmd_o = ~c;
  endtask : send
  task automatic strobe();
    @(negedge mclk_i);
    load_output_strobe_b_o = 1'b0;
    @(negedge mclk_i);
    load_output_strobe_b_o = 1'b1;
  endtask : strobe
  // only called with power-down off
  task automatic hw_reset();
    @(negedge mclk_i);
    reset_pin_b_o = 1'b0;
  endtask : hw_reset
endmodule : host_model
`default_nettype wire

// ### testbench/tb_dac_update_sequencer.sv
// self-checking bench: host model drives, expectations queued and compared
// assumes shortened reset and clear counts set below; the calc count set below equals the package default of 20
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, g) begin total_checks++; if ((e) !== (g)) begin n_errors++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_dac_update_sequencer;
  import dac_seq_pkg::*;
  localparam int RST_N = 20;
  localparam int CALC_N = 20;
  localparam logic [5:0] CTRL_ADDR = 6'h0c;
  localparam logic [5:0] CLR_ADDR  = 6'h01;
  typedef struct { int kind; int idx; logic [31:0] exp; } note_s;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  wire logic rst_pin_b, clr_b, ld_b, qen, if_sel, tw_sel, pd, wr_b, fs_b, cvalid;
  wire cmd_s cmd;
  logic [NUM_CH*DATA_W-1:0] dac_regs_o;
  logic [NUM_CH-1:0] chan_out_en_o, chan_pd_load_o;
  logic [5:0] monitor_sel_o;
  logic cmd_ready_o, busy_b_o, monitor_output_oe_o, monitor_enable_bit_o;
  logic queue_active_o, if_awake_o;
  if_mode_s if_mode_o;
  int n_errors = 0;
  int total_checks = 0;
  note_s notes[$];
  event chk_ev;
  logic [13:0] exp_dac[NUM_CH];
  string knames[11] = '{"dac", "busy", "msel", "moe", "men", "outen", "qact", "ready",
                        "mode", "awake", "pdload"};
  initial forever #12.5 mclk_i = ~mclk_i;
  host_model host (.mclk_i(mclk_i), .cmd_ready_i(cmd_ready_o), .reset_pin_b_o(rst_pin_b),
    .async_clear_input_b_o(clr_b), .load_output_strobe_b_o(ld_b), .queue_enable_pin_o(qen),
    .interface_select_pin_o(if_sel), .two_wire_select_o(tw_sel), .power_down_o(pd),
    .write_strobe_b_o(wr_b), .frame_sync_b_o(fs_b), .cmd_valid_o(cvalid), .cmd_o(cmd));
  dac_update_sequencer #(.RESET_CNT(RST_N), .POR_CNT(RST_N), .CLEAR_CNT(RST_N),
    .CALC_CNT(CALC_N), .QDEPTH(QUEUE_DEPTH)) DUT (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .reset_pin_b_i(rst_pin_b), .async_clear_input_b_i(clr_b), .load_output_strobe_b_i(ld_b),
    .queue_enable_pin_i(qen), .interface_select_pin_i(if_sel), .two_wire_select_i(tw_sel),
    .power_down_i(pd), .write_strobe_b_i(wr_b), .frame_sync_b_i(fs_b), .cmd_valid_i(cvalid),
    .cmd_i(cmd), .cmd_ready_o(cmd_ready_o), .busy_b_o(busy_b_o), .dac_regs_o(dac_regs_o),
    .chan_out_en_o(chan_out_en_o), .chan_pd_load_o(chan_pd_load_o),
    .monitor_sel_o(monitor_sel_o), .monitor_output_oe_o(monitor_output_oe_o),
    .monitor_enable_bit_o(monitor_enable_bit_o), .queue_active_o(queue_active_o),
    .if_mode_o(if_mode_o), .if_awake_o(if_awake_o));
  function automatic logic [31:0] obs(input int k, input int i);
    case (k)
      0: return 32'(dac_regs_o[i*DATA_W +: DATA_W]);
      1: return 32'(busy_b_o);
      2: return 32'(monitor_sel_o);
      3: return 32'(monitor_output_oe_o);
      4: return 32'(monitor_enable_bit_o);
      5: return 32'(chan_out_en_o[i]);
      6: return 32'(queue_active_o);
      7: return 32'(cmd_ready_o);
      8: return 32'(if_mode_o);
      9: return 32'(if_awake_o);
      default: return 32'(chan_pd_load_o[i]);
    endcase
  endfunction : obs
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // watcher: compares each queued note against the live outputs
  initial begin
    note_s nt;
    forever begin
      @(chk_ev);
      while (notes.size() > 0) begin
        nt = notes.pop_front();
        `CHECK(knames[nt.kind], nt.exp, obs(nt.kind, nt.idx))
      end
    end
  end
  // inputs stay frozen for the 1 ns the watcher needs
  task automatic note_exp(input int k, input int i, input logic [31:0] e);
    notes.push_back(note_s'{k, i, e});
    -> chk_ev;
    #1;
  endtask : note_exp
  task automatic wait_for(input int k, input int i, input logic [31:0] v, input int lim,
                          output int n);
    for (n = 0; n < lim; n++) begin
      @(negedge mclk_i);
      if (obs(k, i) === v) return;
    end
    n_errors++;
    $display("Error wait %s expected %h seen %h", knames[k], v, obs(k, i));
    conclude();
  endtask : wait_for
  task automatic snd(input logic [1:0] r, input logic [5:0] a, input logic [13:0] d,
                     output int w);
    host.send(cmd_s'{r, a, d}, w);
    if (w >= 2000) begin
      n_errors++;
      $display("Error send expected accept seen timeout");
      conclude();
    end
  endtask : snd
  task automatic idle();
    int n;
    wait_for(1, 0, 1, 4000, n);
    wait_for(7, 0, 1, 4000, n);
  endtask : idle
  initial begin
    int n, w, ch, stalls;
    logic [13:0] v, cv;
    logic [5:0] codes[4];
    codes = '{6'h00, 6'h13, MON_LAST_VALID, MON_FLOAT_CODE};
    n = $urandom(55);
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_b_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    note_exp(1, 0, 0);
    note_exp(5, 3, 0);
    note_exp(7, 0, 0);
    idle();
    note_exp(6, 0, 0);
    note_exp(8, 0, 32'h4);
    ch = $urandom_range(38, 0);
    v = 14'($urandom);
    snd(REGSEL_INPUT, 6'(ch), v, w);
    note_exp(1, 0, 0);
    wait_for(9, 0, 1, 6, n);
    note_exp(9, 0, 1);
    host.strobe();
    idle();
    repeat (3) @(negedge mclk_i);
    note_exp(0, ch, 32'(v));
    cv = 14'($urandom);
    snd(REGSEL_SPECIAL, CLR_ADDR, cv, w);
    idle();
    @(negedge mclk_i);
    host.async_clear_input_b_o = 1'b0;
    @(negedge mclk_i);
    host.async_clear_input_b_o = 1'b1;
    wait_for(1, 0, 0, 10, n);
    wait_for(1, 0, 1, RST_N + 8, n);
    note_exp(0, ch, 32'(cv));
    note_exp(0, 39, 32'(cv));
    host.strobe();
    repeat (4) @(negedge mclk_i);
    note_exp(0, ch, 32'(cv));
    // monitor is enabled before any selection
    snd(REGSEL_SPECIAL, CTRL_ADDR, 14'h2200, w);
    idle();
    note_exp(4, 0, 1);
    note_exp(5, 39, 0);
    foreach (codes[i]) begin
      snd(REGSEL_SPECIAL, ADDR_MONITOR, {codes[i], 8'h00}, w);
      idle();
      note_exp(2, 0, 32'(codes[i]));
      note_exp(3, 0, 32'(codes[i] != MON_FLOAT_CODE));
    end
    @(negedge mclk_i);
    host.power_down_o = 1'b1;
    wait_for(5, 0, 0, 10, n);
    note_exp(10, 0, 0);
    note_exp(7, 0, 0);
    note_exp(0, ch, 32'(cv));
    @(negedge mclk_i);
    host.power_down_o = 1'b0;
    wait_for(5, 0, 1, 20, n);
    host.qen = 1'b1;
    snd(REGSEL_INPUT, 6'(ch), ~v, w);
    idle();
    host.hw_reset();
    wait_for(1, 0, 0, 10, n);
    host.strobe();
    wait_for(1, 0, 1, RST_N + 10, n);
    `CHECK("reset_len", 1'b1, (n + 2 >= RST_N - 2) && (n + 2 <= RST_N + 1))
    note_exp(0, ch, 0);
    note_exp(4, 0, 0);
    note_exp(6, 0, 1);
    repeat (RST_N + 5) @(negedge mclk_i);
    note_exp(1, 0, 1);
    @(negedge mclk_i);
    host.reset_pin_b_o = 1'b1;
    foreach (exp_dac[i]) exp_dac[i] = '0;
    stalls = 0;
    for (int k = 0; k < 150; k++) begin
      ch = $urandom_range(NUM_CH - 1, 0);
      v = 14'($urandom);
      exp_dac[ch] = v;
      snd(REGSEL_INPUT, 6'(ch), v, w);
      if (w > 1) stalls++;
    end
    `CHECK("queue_full", 1'b1, stalls > 0)
    note_exp(1, 0, 0);
    idle();
    host.strobe();
    repeat (4) @(negedge mclk_i);
    foreach (exp_dac[i]) note_exp(0, i, 32'(exp_dac[i]));
    host.qen = 1'b0;
    for (int m = 1; m < 3; m++) begin
      @(negedge mclk_i);
      host.interface_select_pin_o = 1'b1;
      host.two_wire_select_o = (m == 2);
      repeat (3) @(negedge mclk_i);
      note_exp(8, 0, (m == 2) ? 32'h2 : 32'h1);
    end
    // serial write wakes via frame sync; control bit13 low selects the load
    snd(REGSEL_SPECIAL, CTRL_ADDR, 14'h0000, w);
    wait_for(9, 0, 1, 6, n);
    note_exp(9, 0, 1);
    idle();
    @(negedge mclk_i);
    host.power_down_o = 1'b1;
    wait_for(10, 5, 1, 10, n);
    note_exp(10, 5, 1);
    conclude();
  end
endmodule : tb_dac_update_sequencer
`default_nettype wire
